/* File: src/gpx_pkg.sv */
package gpx_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_IN = 8'h00;
   localparam logic [7:0] OFS_OUT = 8'h01;
   localparam logic [7:0] OFS_INV = 8'h02;
   localparam logic [7:0] OFS_DIR = 8'h03;
   localparam logic [7:0] OFS_DRV_LO = 8'h40;
   localparam logic [7:0] OFS_DRV_HI = 8'h41;
   localparam logic [7:0] OFS_HOLD = 8'h42;
   localparam logic [7:0] OFS_PULL_EN = 8'h43;
   localparam logic [7:0] OFS_PULL_SEL = 8'h44;
   localparam logic [7:0] OFS_MASK = 8'h45;
   localparam logic [7:0] OFS_SRC = 8'h46;
   localparam logic [7:0] OFS_STAGE = 8'h4F;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OUT = 8'hFF;
   localparam logic [7:0] RST_INV = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_DRV = 8'hFF;
   localparam logic [7:0] RST_HOLD = 8'h00;
   localparam logic [7:0] RST_PULL_EN = 8'hFF;
   localparam logic [7:0] RST_PULL_SEL = 8'hFF;
   localparam logic [7:0] RST_MASK = 8'hFF;
   localparam logic [7:0] RST_SRC = 8'h00;
   localparam logic [7:0] RST_STAGE = 8'h00;
   // ------------------------------------------------------------
   // Field positions and bus constants
   // ------------------------------------------------------------
   localparam int PTR_EXT_BIT = 6;
   localparam int STAGE_OD_BIT = 0;
   localparam int DRV_W = 2;
   localparam int PINS_PER_DRV = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Fixed upper address bits, arbitrary value
   localparam logic [3:0] SLV_ADDR_HI = 4'h4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // ------------------------------------------------------------
   // Serial slave states
   // ------------------------------------------------------------
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_RX = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TX = 5'b01000,
      ST_RACK = 5'b10000
   } gpx_state_t;
   typedef enum logic [1:0]
   {
      BK_ADDR = 2'h0,
      BK_CMD = 2'h1,
      BK_DATA = 2'h2
   } gpx_kind_t;
endpackage

/* File: src/gpx_sync.sv */
`timescale 1ns/10ps
module gpx_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_ff <= INIT;
         q_ff <= INIT;
      end
      else
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

/* File: src/gpx_top.sv */
`timescale 1ns/10ps
module gpx_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic strap_addr_bit0,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic [7:0] port_pin_i,
   output logic [7:0] port_pin_o,
   output logic [7:0] port_pin_oe,
   output logic [15:0] drive_code,
   output logic [7:0] pull_on,
   output logic [7:0] pull_up_sel,
   output logic int_n_o,
   output logic int_n_oe
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [12:0] raw_in;
   logic [12:0] syn_in;
   logic scl_s;
   logic sda_s;
   logic [2:0] strap_s;
   logic [7:0] pin_s;

   assign raw_in = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, scl_i, sda_i, port_pin_i};

   gpx_sync #(.W(13), .INIT(13'h1F00)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(raw_in),
      .q(syn_in)
   );

   assign pin_s = syn_in[7:0];
   assign sda_s = syn_in[8];
   assign scl_s = syn_in[9];
   assign strap_s = syn_in[12:10];

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] ptr_ff;
   logic [7:0] out_ff;
   logic [7:0] inv_ff;
   logic [7:0] dir_ff;
   logic [7:0] drv_lo_ff;
   logic [7:0] drv_hi_ff;
   logic [7:0] hold_en_ff;
   logic [7:0] pull_en_ff;
   logic [7:0] pull_sel_ff;
   logic [7:0] mask_ff;
   logic [7:0] src_ff;
   logic [7:0] held_ff;
   logic [7:0] ref_ff;
   logic [7:0] stage_ff;

   // ------------------------------------------------------------
   // Serial slave state
   // ------------------------------------------------------------
   gpx_pkg::gpx_state_t state_ff;
   gpx_pkg::gpx_kind_t kind_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic rw_ff;
   logic nack_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic sda_o_ff;
   logic sda_oe_ff;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic byte_done;
   logic addr_match;
   logic wr_strobe;
   logic rd_load;
   logic rd_in_clear;
   logic [7:0] rd_data;
   logic [7:0] in_view;
   logic [7:0] pin_chg;
   logic [7:0] nxt_src;

   localparam int PTR_HI_BIT = 7;

   function automatic logic in_map(input logic [7:0] p);
      in_map = (p == gpx_pkg::OFS_IN) || (p == gpx_pkg::OFS_OUT) ||
               (p == gpx_pkg::OFS_INV) || (p == gpx_pkg::OFS_DIR) ||
               (!p[PTR_HI_BIT] && p[gpx_pkg::PTR_EXT_BIT] &&
                ((p[5:3] == 3'h0 && p[2:0] <= 3'h6) || p == gpx_pkg::OFS_STAGE));
   endfunction

   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   assign byte_done = (bit_cnt_ff == gpx_pkg::BITS_PER_BYTE);
   assign addr_match = (shift_ff[7:1] == {gpx_pkg::SLV_ADDR_HI, strap_s});
   assign wr_strobe = (state_ff == gpx_pkg::ST_RX) && scl_fall && byte_done &&
                      (kind_ff == gpx_pkg::BK_DATA);
   assign rd_load = scl_fall && rw_ff &&
                    (((state_ff == gpx_pkg::ST_ACK) && (kind_ff == gpx_pkg::BK_ADDR)) ||
                     ((state_ff == gpx_pkg::ST_RACK) && !nack_ff));
   assign rd_in_clear = rd_load && (ptr_ff == gpx_pkg::OFS_IN);

   // ------------------------------------------------------------
   // Pin change tracking
   // ------------------------------------------------------------
   // Only input pins raise events; driven pins would flag every write
   assign pin_chg = (pin_s ^ ref_ff) & dir_ff;
   // Latched bits stay set after the pin returns; plain bits follow it
   assign nxt_src = rd_in_clear ? 8'h00 : ((src_ff & hold_en_ff) | pin_chg);
   // Live pin level, or held value while a latched change waits
   assign in_view = ((held_ff & hold_en_ff & src_ff) |
                     (pin_s & ~(hold_en_ff & src_ff))) ^ inv_ff;

   // ------------------------------------------------------------
   // Read data select
   // ------------------------------------------------------------
   always_comb
   begin
      case (ptr_ff)
         gpx_pkg::OFS_IN: rd_data = in_view;
         gpx_pkg::OFS_OUT: rd_data = out_ff;
         gpx_pkg::OFS_INV: rd_data = inv_ff;
         gpx_pkg::OFS_DIR: rd_data = dir_ff;
         gpx_pkg::OFS_DRV_LO: rd_data = drv_lo_ff;
         gpx_pkg::OFS_DRV_HI: rd_data = drv_hi_ff;
         gpx_pkg::OFS_HOLD: rd_data = hold_en_ff;
         gpx_pkg::OFS_PULL_EN: rd_data = pull_en_ff;
         gpx_pkg::OFS_PULL_SEL: rd_data = pull_sel_ff;
         gpx_pkg::OFS_MASK: rd_data = mask_ff;
         gpx_pkg::OFS_SRC: rd_data = src_ff & ~mask_ff;
         gpx_pkg::OFS_STAGE: rd_data = stage_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Serial slave
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end
      else
      begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_ff <= gpx_pkg::ST_IDLE;
         kind_ff <= gpx_pkg::BK_ADDR;
         bit_cnt_ff <= gpx_pkg::CNT_ZERO;
         shift_ff <= 8'h00;
         rw_ff <= 1'b0;
         nack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end
      else if (bus_start)
      begin
         state_ff <= gpx_pkg::ST_RX;
         kind_ff <= gpx_pkg::BK_ADDR;
         bit_cnt_ff <= gpx_pkg::CNT_ZERO;
         sda_oe_ff <= 1'b0;
      end
      else if (bus_stop)
      begin
         state_ff <= gpx_pkg::ST_IDLE;
         sda_oe_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            gpx_pkg::ST_IDLE:
            begin
               sda_oe_ff <= 1'b0;
            end
            gpx_pkg::ST_RX:
            begin
               if (scl_rise && !byte_done)
               begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  if ((kind_ff == gpx_pkg::BK_ADDR) && !addr_match)
                  begin
                     // Foreign address: stay off the bus until next start
                     state_ff <= gpx_pkg::ST_IDLE;
                  end
                  else
                  begin
                     if (kind_ff == gpx_pkg::BK_ADDR)
                     begin
                        rw_ff <= shift_ff[0];
                     end
                     state_ff <= gpx_pkg::ST_ACK;
                     sda_oe_ff <= 1'b1;
                  end
               end
            end
            gpx_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  bit_cnt_ff <= gpx_pkg::CNT_ZERO;
                  if (rd_load)
                  begin
                     state_ff <= gpx_pkg::ST_TX;
                     shift_ff <= rd_data;
                     sda_oe_ff <= ~rd_data[7];
                  end
                  else
                  begin
                     state_ff <= gpx_pkg::ST_RX;
                     sda_oe_ff <= 1'b0;
                     kind_ff <= (kind_ff == gpx_pkg::BK_ADDR) ? gpx_pkg::BK_CMD :
                                gpx_pkg::BK_DATA;
                  end
               end
            end
            gpx_pkg::ST_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_ff == gpx_pkg::BITS_PER_BYTE - 4'h1)
                  begin
                     state_ff <= gpx_pkg::ST_RACK;
                     sda_oe_ff <= 1'b0;
                  end
                  else
                  begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     sda_oe_ff <= ~shift_ff[6];
                  end
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
            end
            gpx_pkg::ST_RACK:
            begin
               if (scl_rise)
               begin
                  nack_ff <= sda_s;
               end
               else if (scl_fall)
               begin
                  bit_cnt_ff <= gpx_pkg::CNT_ZERO;
                  if (rd_load)
                  begin
                     // Same register again: the pointer does not advance
                     state_ff <= gpx_pkg::ST_TX;
                     shift_ff <= rd_data;
                     sda_oe_ff <= ~rd_data[7];
                  end
                  else
                  begin
                     state_ff <= gpx_pkg::ST_IDLE;
                  end
               end
            end
            default:
            begin
               state_ff <= gpx_pkg::ST_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sda_o_ff <= 1'b0;
      end
      else
      begin
         sda_o_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ptr_ff <= gpx_pkg::OFS_IN;
         out_ff <= gpx_pkg::RST_OUT;
         inv_ff <= gpx_pkg::RST_INV;
         dir_ff <= gpx_pkg::RST_DIR;
         drv_lo_ff <= gpx_pkg::RST_DRV;
         drv_hi_ff <= gpx_pkg::RST_DRV;
         hold_en_ff <= gpx_pkg::RST_HOLD;
         pull_en_ff <= gpx_pkg::RST_PULL_EN;
         pull_sel_ff <= gpx_pkg::RST_PULL_SEL;
         mask_ff <= gpx_pkg::RST_MASK;
         stage_ff <= gpx_pkg::RST_STAGE;
      end
      else if ((state_ff == gpx_pkg::ST_RX) && scl_fall && byte_done &&
               (kind_ff == gpx_pkg::BK_CMD))
      begin
         ptr_ff <= shift_ff;
      end
      else if (wr_strobe && in_map(ptr_ff))
      begin
         case (ptr_ff)
            gpx_pkg::OFS_OUT: out_ff <= shift_ff;
            gpx_pkg::OFS_INV: inv_ff <= shift_ff;
            gpx_pkg::OFS_DIR: dir_ff <= shift_ff;
            gpx_pkg::OFS_DRV_LO: drv_lo_ff <= shift_ff;
            gpx_pkg::OFS_DRV_HI: drv_hi_ff <= shift_ff;
            gpx_pkg::OFS_HOLD: hold_en_ff <= shift_ff;
            gpx_pkg::OFS_PULL_EN: pull_en_ff <= shift_ff;
            gpx_pkg::OFS_PULL_SEL: pull_sel_ff <= shift_ff;
            gpx_pkg::OFS_MASK: mask_ff <= shift_ff;
            gpx_pkg::OFS_STAGE: stage_ff <= {7'h00, shift_ff[gpx_pkg::STAGE_OD_BIT]};
            default: stage_ff <= stage_ff;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Interrupt sources and held input values
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         src_ff <= gpx_pkg::RST_SRC;
         held_ff <= 8'h00;
         ref_ff <= 8'h00;
      end
      else
      begin
         src_ff <= nxt_src;
         // Track the pin until a change is flagged, so the held value survives a return
         held_ff <= (held_ff & src_ff) | (pin_s & ~src_ff);
         if (rd_in_clear)
         begin
            ref_ff <= pin_s;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   logic [7:0] pin_o_ff;
   logic [7:0] pin_oe_ff;
   logic [7:0] pull_on_ff;
   logic int_oe_ff;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         logic od_release;
         assign od_release = stage_ff[gpx_pkg::STAGE_OD_BIT] & out_ff[gi];
         always_ff @(posedge clk)
         begin
            if (sys_rst)
            begin
               pin_o_ff[gi] <= 1'b1;
               pin_oe_ff[gi] <= 1'b0;
               pull_on_ff[gi] <= 1'b1;
            end
            else
            begin
               pin_o_ff[gi] <= out_ff[gi];
               // Input pins stay released whatever the output bit holds
               pin_oe_ff[gi] <= ~dir_ff[gi] & ~od_release;
               pull_on_ff[gi] <= pull_en_ff[gi] & ~(stage_ff[gpx_pkg::STAGE_OD_BIT] &
                                                   ~dir_ff[gi]);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         int_oe_ff <= 1'b0;
      end
      else
      begin
         int_oe_ff <= |(src_ff & ~mask_ff);
      end
   end

   assign sda_o = sda_o_ff;
   assign sda_oe = sda_oe_ff;
   assign port_pin_o = pin_o_ff;
   assign port_pin_oe = pin_oe_ff;
   // Pin n code at bits 2n+1:2n; pins 7..4 from the high register
   assign drive_code = {drv_hi_ff, drv_lo_ff};
   assign pull_on = pull_on_ff;
   assign pull_up_sel = pull_sel_ff;
   assign int_n_o = sda_o_ff;
   assign int_n_oe = int_oe_ff;
endmodule

/* File: tb/gpx_i2c_master.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Serial bus master, data line open drain
// ------------------------------------------------------------
module gpx_i2c_master (
   input wire logic clk,
   input wire logic sda,
   input wire logic [6:0] dev,
   output logic scl,
   output logic sda_low
);
   logic ack_ok;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
      ack_ok = 1'b1;
   end
   // Ten cycles per phase, twice the minimum
   task automatic wt();
      repeat (10) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      wt();
      scl = 1'b1;
      wt();
      r = sda;
      scl = 1'b0;
      wt();
   endtask
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic a);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(last, r);
      a = ~r;
   endtask
   task automatic start();
      sda_low = 1'b0;
      scl = 1'b1;
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b0;
      wt();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b0;
      wt();
   endtask
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      byte_io(d, 1'b1, q, a);
      ack_ok &= a;
   endtask
   // Pointer only when n is low
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic n);
      ack_ok = 1'b1;
      start();
      send({dev, 1'b0});
      send(cmd);
      if (n)
         send(d);
      stop();
   endtask
   task automatic rdc(output logic [7:0] q);
      logic a;
      start();
      send({dev, 1'b1});
      byte_io(8'hFF, 1'b1, q, a);
      stop();
   endtask
   task automatic rd(input logic [7:0] cmd, output logic [7:0] q);
      wr(cmd, 8'h00, 1'b0);
      rdc(q);
   endtask
   task automatic probe(input logic [6:0] adr, output logic a);
      logic [7:0] q;
      start();
      byte_io({adr, 1'b0}, 1'b1, q, a);
      stop();
   endtask
endmodule

/* File: tb/gpx_top_properties.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module gpx_top_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_i,
   input wire logic sda_oe,
   input wire logic [7:0] port_pin_o,
   input wire logic [7:0] port_pin_oe,
   input wire logic [15:0] drive_code,
   input wire logic int_n_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_RST_OUT: assert property ($fell(sys_rst) |-> port_pin_o == 8'hFF)
      else $error("output levels not at reset value");
   AST_RST_DIR: assert property ($fell(sys_rst) |-> (port_pin_oe == 8'h00) [*8])
      else $error("pin driver on after reset");
   AST_RST_DRV: assert property ($fell(sys_rst) |-> drive_code == 16'hFFFF)
      else $error("drive codes not at reset value");
   AST_RST_INT: assert property ($fell(sys_rst) |-> (!int_n_oe) [*8])
      else $error("interrupt active after reset");
   // Data may only move while the serial clock is low
   AST_SDA_LOWPH: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line changed with clock high");
   AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("acknowledge too short");
   AST_PIN_UPD: assert property ($changed(port_pin_o) |-> (!scl_i) [*4])
      else $error("output level changed outside a byte end");
   AST_DRV_UPD: assert property ($changed(drive_code) |-> !scl_i)
      else $error("drive code changed outside a byte end");
   AST_OE_UPD: assert property ($changed(port_pin_oe) |-> !scl_i)
      else $error("driver enable changed outside a byte end");
   cover property ($rose(int_n_oe));
   cover property ($changed(drive_code));
   cover property ($rose(sda_oe));
endmodule

bind gpx_top gpx_top_properties u_props (
   .clk(clk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_oe(sda_oe), .port_pin_o(port_pin_o),
   .port_pin_oe(port_pin_oe), .drive_code(drive_code), .int_n_oe(int_n_oe)
);

/* File: tb/gpx_top_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) \
      begin \
         err_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module gpx_top_tb_top;
   logic clk;
   logic sys_rst;
   logic scl;
   logic sda;
   logic sda_low;
   logic sda_oe;
   logic int_n_oe;
   logic ack;
   logic [2:0] strap;
   logic [7:0] ext;
   logic [7:0] q;
   logic [7:0] pin_o;
   logic [7:0] pin_oe;
   logic [7:0] pin_lvl;
   logic [15:0] drv;
   logic [7:0] pull_on;
   logic [7:0] pull_sel;
   logic sda_o;
   logic int_n_o;
   int err_count;
   int checks_done;
   logic [15:0] rv [11] = '{16'h01FF, 16'h0200, 16'h03FF, 16'h40FF, 16'h41FF, 16'h4200,
                            16'h43FF, 16'h44FF, 16'h45FF, 16'h4600, 16'h4F00};
   logic [7:0] bad [2] = '{8'h04, 8'h81};
   // Pull-up on the data line, outputs win over the outside level
   assign sda = ~(sda_low | sda_oe);
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext);
   always #12.5 clk = ~clk;
   gpx_top u_dut (
      .clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
      .port_pin_i(pin_lvl), .port_pin_o(pin_o), .port_pin_oe(pin_oe), .drive_code(drv),
      .pull_on(pull_on), .pull_up_sel(pull_sel), .int_n_o(int_n_o), .int_n_oe(int_n_oe)
   );
   gpx_i2c_master u_mst (
      .clk(clk), .sda(sda), .dev({gpx_pkg::SLV_ADDR_HI, strap}), .scl(scl), .sda_low(sda_low)
   );
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      test_done();
   end
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      strap = 3'h5;
      ext = 8'h5A;
      err_count = 0;
      checks_done = 0;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < 11; i++)
      begin
         u_mst.rd(rv[i][15:8], q);
         `CHK("reset value", rv[i][7:0], q)
      end
      $display("test reset done");
      u_mst.rd(8'h00, q);
      `CHK("input", 8'h5A, q)
      u_mst.wr(8'h02, 8'h0F, 1'b1);
      u_mst.wr(8'h00, 8'h33, 1'b1);
      u_mst.rd(8'h00, q);
      `CHK("inverted input", 8'h55, q)
      `CHK("pins after ro write", 8'hFF, pin_o)
      $display("test input done");
      ext = 8'hDA;
      repeat (10) @(negedge clk);
      `CHK("masked irq", 1'b0, int_n_oe)
      u_mst.wr(8'h45, 8'hEF, 1'b1);
      ext = 8'hCA;
      repeat (10) @(negedge clk);
      `CHK("irq", 1'b1, int_n_oe)
      u_mst.wr(8'h46, 8'h00, 1'b1);
      u_mst.rd(8'h46, q);
      `CHK("status", 8'h10, q)
      u_mst.rd(8'h00, q);
      `CHK("input", 8'hC5, q)
      `CHK("irq cleared", 1'b0, int_n_oe)
      u_mst.wr(8'h02, 8'h00, 1'b1);
      u_mst.wr(8'h45, 8'hFF, 1'b1);
      $display("test interrupt done");
      u_mst.wr(8'h01, 8'hA5, 1'b1);
      `CHK("oe all input", 8'h00, pin_oe)
      u_mst.wr(8'h03, 8'hF0, 1'b1);
      `CHK("oe", 8'h0F, pin_oe)
      `CHK("level", 8'hA5, pin_o)
      u_mst.rd(8'h00, q);
      `CHK("pin view", 8'hC5, q)
      u_mst.rd(8'h01, q);
      `CHK("out reg", 8'hA5, q)
      u_mst.rdc(q);
      `CHK("held ptr", 8'hA5, q)
      $display("test output done");
      u_mst.wr(8'h40, 8'h1B, 1'b1);
      u_mst.wr(8'h41, 8'hE4, 1'b1);
      `CHK("drive", 16'hE41B, drv)
      `CHK("acks", 1'b1, u_mst.ack_ok)
      u_mst.rd(8'h41, q);
      `CHK("drive hi", 8'hE4, q)
      $display("test drive done");
      for (int i = 0; i < 2; i++)
      begin
         u_mst.wr(bad[i], 8'h3C, 1'b1);
         u_mst.rd(bad[i], q);
         `CHK("unmapped", 8'h00, q)
      end
      `CHK("level kept", 8'hA5, pin_o)
      `CHK("oe kept", 8'h0F, pin_oe)
      $display("test unmapped done");
      u_mst.wr(8'h43, 8'h3C, 1'b1);
      u_mst.wr(8'h44, 8'h0F, 1'b1);
      u_mst.wr(8'h4F, 8'h01, 1'b1);
      `CHK("open drain oe", 8'h0A, pin_oe)
      `CHK("pull on", 8'h30, pull_on)
      `CHK("pull select", 8'h0F, pull_sel)
      u_mst.rd(8'h4F, q);
      `CHK("stage", 8'h01, q)
      `CHK("data pin level", 1'b0, sda_o)
      `CHK("irq pin level", 1'b0, int_n_o)
      $display("test stage done");
      for (int k = 0; k < 8; k++)
      begin
         strap = k[2:0];
         repeat (10) @(negedge clk);
         u_mst.probe({gpx_pkg::SLV_ADDR_HI, k[2:0]}, ack);
         `CHK("own address", 1'b1, ack)
         u_mst.probe({gpx_pkg::SLV_ADDR_HI, k[2:0] ^ 3'h5}, ack);
         `CHK("other address", 1'b0, ack)
      end
      $display("test address done");
      test_done();
   end
endmodule
